// ===== src/usbdr_registers.v
// USB device control and status register bank
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "usbdr_consts.vh"
// Function
// - Event flags set regardless of enables; software writes zero to clear, one ignored.
// - Enable bits 6,5,4,3,2,0 gate the matching flags onto the device interrupt.
// - End-of-reset enable bit is set after reset.
// - Reserved bits read zero; software must not write ones there.
// - Writing one to address bit 7 activates the address; only hardware clears it.
// - Frame number upper three bits stored in bits 2 to 0, even if corrupted.
// - Low eight frame number bits sit in their own read-only register.
// - CRC error flag bit 4 updates together with the start-of-frame flag.
// - One FIFO reset bit per endpoint; set holds that FIFO in reset.
// - Stall request bit 5 set by software, cleared on new SETUP or by a stall cancel write.
// - Stall cancel bit 4 disables stalling and self-clears next cycle.
// - Toggle reset bit 3 forces data toggle zero next packet; self-clears.
// - Transfer kind bits 7:6: control, isochronous, bulk, interrupt.
// - Direction bit 0 set means IN; control endpoints use OUT.
// - Size bits 6-4 code 8 to 512 bytes; code seven reserved.
// - Bank bits 3:2: one bank or double; upper bit set reserved.
// - End-of-reset flag set on bus reset end; interrupt only if enabled.
// - Start-of-frame flag set on each detected frame start packet.
module usbdr_registers
#(
   parameter ENDPOINTS = 7
)
(
   // Clock and reset
   input  wire                   clock,
   input  wire                   reset_n,

   // Register port
   input  wire [7:0]             reg_addr,
   input  wire [7:0]             reg_wdata,
   input  wire                   reg_write,
   input  wire                   reg_read,
   output reg  [7:0]             reg_rdata,

   // Bus events from the serial engine
   input  wire                   ev_upstream_resume,
   input  wire                   ev_end_resume,
   input  wire                   ev_wake,
   input  wire                   ev_bus_reset_end,
   input  wire                   ev_suspend,

   // Frame start from the serial engine
   input  wire                   ev_frame_start,
   input  wire [10:0]            ev_frame_num,
   input  wire                   ev_frame_crc_bad,

   // Address and endpoint events
   input  wire                   ev_addr_done,
   input  wire [ENDPOINTS-1:0]   ev_setup_rx,
   input  wire [ENDPOINTS-1:0]   ev_stall_cancel_done,
   input  wire [ENDPOINTS-1:0]   ev_toggle_reset_done,

   // Device interrupt and address
   output reg                    device_irq,
   output reg  [6:0]             device_addr_field,
   output reg                    address_activate,

   // Endpoint controls
   output reg  [ENDPOINTS-1:0]   endpoint_fifo_clear,
   output reg  [ENDPOINTS-1:0]   endpoint_on,
   output reg  [ENDPOINTS-1:0]   stall_request,
   output reg  [ENDPOINTS-1:0]   stall_cancel,
   output reg  [ENDPOINTS-1:0]   toggle_reset,

   // Endpoint configuration
   output reg  [2*ENDPOINTS-1:0] transfer_kind,
   output reg  [ENDPOINTS-1:0]   endpoint_direction,
   output reg  [3*ENDPOINTS-1:0] endpoint_bytes,
   output reg  [2*ENDPOINTS-1:0] endpoint_bank_count
);

   // Register state
   reg  [7:0] irq_flags;
   reg  [7:0] device_irq_enable;
   reg  [2:0] frame_num_upper;
   reg  [7:0] frame_num_lower;
   reg        frame_num_crc_err;
   reg  [2:0] endpoint_index;

   // Combinational values
   wire [7:0] next_irq_flags;
   reg  [7:0] next_rdata;
   reg  [7:0] ep_rdata;
   wire [7:0] irq_events;
   wire [7:0] flag_mask;
   wire       wr_en;
   wire       sel_valid;

   // Decoded write strobes
   wire       wr_flags;
   wire       wr_enable;
   wire       wr_address;
   wire       wr_select;
   wire       wr_fifo_rst;
   wire       wr_control;
   wire       wr_type_dir;
   wire       wr_size_bank;
   wire       addr_set;

   // Endpoint read views
   wire [8*ENDPOINTS-1:0] ctl_view;
   wire [8*ENDPOINTS-1:0] cfg0_view;
   wire [8*ENDPOINTS-1:0] cfg1_view;

   assign irq_events = {1'b0, ev_upstream_resume, ev_end_resume, ev_wake,
                        ev_bus_reset_end, ev_frame_start, 1'b0, ev_suspend};
   assign flag_mask  = `USBDR_IRQ_MASK;
   assign wr_en      = reg_write;
   assign sel_valid  = (endpoint_index < ENDPOINTS);

   // Write strobes per register
   assign wr_flags     = wr_en && (reg_addr == `USBDR_OFF_IRQ_FLAGS);
   assign wr_enable    = wr_en && (reg_addr == `USBDR_OFF_IRQ_ENABLE);
   assign wr_address   = wr_en && (reg_addr == `USBDR_OFF_ADDRESS);
   assign wr_select    = wr_en && (reg_addr == `USBDR_OFF_EP_SELECT);
   assign wr_fifo_rst  = wr_en && (reg_addr == `USBDR_OFF_EP_FIFO_RST);
   assign wr_control   = wr_en && (reg_addr == `USBDR_OFF_EP_CONTROL);
   assign wr_type_dir  = wr_en && (reg_addr == `USBDR_OFF_EP_TYPE_DIR);
   assign wr_size_bank = wr_en && (reg_addr == `USBDR_OFF_EP_SIZE_BANK);
   assign addr_set     = wr_address && reg_wdata[`USBDR_BIT_ADDR_ACT];

   // Flags: software clears by writing zero, events win over the clear
   genvar f;
   generate
      for (f = 0; f < 8; f = f + 1)
      begin : g_flag
         wire cleared;

         assign cleared = wr_flags && !reg_wdata[f];
         assign next_irq_flags[f] = flag_mask[f] &&
                                    (irq_events[f] || (irq_flags[f] && !cleared));
      end
   endgenerate

   // Event flags
   always @(posedge clock)
   begin
      if (!reset_n)
         irq_flags <= 8'h00;
      else
         irq_flags <= next_irq_flags;
   end

   // Interrupt enables, end-of-reset enabled out of reset
   always @(posedge clock)
   begin
      if (!reset_n)
         device_irq_enable <= `USBDR_IRQ_EN_RESET;
      else if (wr_enable)
         device_irq_enable <= reg_wdata & `USBDR_IRQ_MASK;
   end

   // Device interrupt from the flags of the coming cycle
   always @(posedge clock)
   begin
      if (!reset_n)
         device_irq <= 1'b0;
      else
         device_irq <= |(next_irq_flags & device_irq_enable);
   end

   // Device address field, loaded on every address write
   always @(posedge clock)
   begin
      if (!reset_n)
         device_addr_field <= 7'h00;
      else if (wr_address)
         device_addr_field <= reg_wdata[6:0];
   end

   // Address activation, set by software, cleared only by the engine
   always @(posedge clock)
   begin
      if (!reset_n)
         address_activate <= 1'b0;
      else if (addr_set)
         address_activate <= 1'b1;
      else if (ev_addr_done)
         address_activate <= 1'b0;
   end

   // Frame number and its CRC status, taken with each frame start
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         frame_num_upper   <= 3'h0;
         frame_num_lower   <= 8'h00;
         frame_num_crc_err <= 1'b0;
      end
      else if (ev_frame_start)
      begin
         frame_num_upper   <= ev_frame_num[10:8];
         frame_num_lower   <= ev_frame_num[7:0];
         frame_num_crc_err <= ev_frame_crc_bad;
      end
   end

   // Endpoint selection
   always @(posedge clock)
   begin
      if (!reset_n)
         endpoint_index <= 3'h0;
      else if (wr_select)
         endpoint_index <= reg_wdata[2:0];
   end

   // Per endpoint registers
   genvar e;
   generate
      for (e = 0; e < ENDPOINTS; e = e + 1)
      begin : g_ep
         // Write strobes of this endpoint
         wire sel;
         wire wr_ctl;
         wire wr_cfg0;
         wire wr_cfg1;
         assign sel     = (endpoint_index == e);
         assign wr_ctl  = wr_control && sel;
         assign wr_cfg0 = wr_type_dir && sel;
         assign wr_cfg1 = wr_size_bank && sel;

         // Views of this endpoint for the read multiplexer
         assign ctl_view[8*e+7:8*e]  = {2'h0, stall_request[e], stall_cancel[e],
                                        toggle_reset[e], 2'h0, endpoint_on[e]};
         assign cfg0_view[8*e+7:8*e] = {transfer_kind[2*e+1:2*e], 5'h00,
                                        endpoint_direction[e]};
         assign cfg1_view[8*e+7:8*e] = {1'b0, endpoint_bytes[3*e+2:3*e],
                                        endpoint_bank_count[2*e+1:2*e], 2'h0};

         // FIFO reset bit, held until software clears it
         always @(posedge clock)
         begin
            if (!reset_n)
               endpoint_fifo_clear[e] <= 1'b0;
            else if (wr_fifo_rst)
               endpoint_fifo_clear[e] <= reg_wdata[e];
         end

         // Endpoint enable
         always @(posedge clock)
         begin
            if (!reset_n)
               endpoint_on[e] <= 1'b0;
            else if (wr_ctl)
               endpoint_on[e] <= reg_wdata[`USBDR_BIT_EP_ON];
         end

         // Stall request, dropped by a new SETUP or by a stall cancel
         always @(posedge clock)
         begin
            if (!reset_n)
               stall_request[e] <= 1'b0;
            else if (wr_ctl && reg_wdata[`USBDR_BIT_STALL_REQ])
               stall_request[e] <= 1'b1;
            else if (ev_setup_rx[e] || (wr_ctl && reg_wdata[`USBDR_BIT_STALL_CANCEL]))
               stall_request[e] <= 1'b0;
         end

         // Stall cancel, a one-cycle pulse
         always @(posedge clock)
         begin
            if (!reset_n)
               stall_cancel[e] <= 1'b0;
            else if (wr_ctl && reg_wdata[`USBDR_BIT_STALL_CANCEL])
               stall_cancel[e] <= 1'b1;
            else if (stall_cancel[e] || ev_stall_cancel_done[e])
               stall_cancel[e] <= 1'b0;
         end

         // Toggle reset, a one-cycle pulse
         always @(posedge clock)
         begin
            if (!reset_n)
               toggle_reset[e] <= 1'b0;
            else if (wr_ctl && reg_wdata[`USBDR_BIT_TOGGLE_RST])
               toggle_reset[e] <= 1'b1;
            else if (toggle_reset[e] || ev_toggle_reset_done[e])
               toggle_reset[e] <= 1'b0;
         end

         // Transfer kind and direction, control endpoints forced to OUT
         always @(posedge clock)
         begin
            if (!reset_n)
            begin
               transfer_kind[2*e+1:2*e] <= `USBDR_KIND_CONTROL;
               endpoint_direction[e]    <= 1'b0;
            end
            else if (wr_cfg0)
            begin
               transfer_kind[2*e+1:2*e] <= reg_wdata[7:6];
               endpoint_direction[e]    <= (reg_wdata[7:6] == `USBDR_KIND_CONTROL) ?
                                           1'b0 : reg_wdata[0];
            end
         end

         // Size, the reserved code leaves the field unchanged
         always @(posedge clock)
         begin
            if (!reset_n)
               endpoint_bytes[3*e+2:3*e] <= 3'h0;
            else if (wr_cfg1 && reg_wdata[6:4] != `USBDR_SIZE_RESERVED)
               endpoint_bytes[3*e+2:3*e] <= reg_wdata[6:4];
         end

         // Bank count, reserved codes leave the field unchanged
         always @(posedge clock)
         begin
            if (!reset_n)
               endpoint_bank_count[2*e+1:2*e] <= 2'h0;
            else if (wr_cfg1 && !reg_wdata[3])
               endpoint_bank_count[2*e+1:2*e] <= reg_wdata[3:2];
         end
      end
   endgenerate

   // Endpoint part of the read multiplexer, zero for an unused index
   always @*
   begin
      ep_rdata = 8'h00;
      if (sel_valid)
      begin
         case (reg_addr)
            `USBDR_OFF_EP_CONTROL:   ep_rdata = ctl_view[8*endpoint_index +: 8];
            `USBDR_OFF_EP_TYPE_DIR:  ep_rdata = cfg0_view[8*endpoint_index +: 8];
            `USBDR_OFF_EP_SIZE_BANK: ep_rdata = cfg1_view[8*endpoint_index +: 8];
            default:                 ep_rdata = 8'h00;
         endcase
      end
   end

   // Read multiplexer, data stands the cycle after the strobe
   always @*
   begin
      next_rdata = 8'h00;
      case (reg_addr)
         `USBDR_OFF_IRQ_FLAGS:   next_rdata = irq_flags;
         `USBDR_OFF_IRQ_ENABLE:  next_rdata = device_irq_enable;
         `USBDR_OFF_ADDRESS:     next_rdata = {address_activate, device_addr_field};
         `USBDR_OFF_FNUM_HIGH:   next_rdata = {5'h00, frame_num_upper};
         `USBDR_OFF_FNUM_LOW:    next_rdata = frame_num_lower;
         `USBDR_OFF_FRAME_CRC:   next_rdata = {3'h0, frame_num_crc_err, 4'h0};
         `USBDR_OFF_EP_SELECT:   next_rdata = {5'h00, endpoint_index};
         `USBDR_OFF_EP_FIFO_RST: next_rdata = {{(8-ENDPOINTS){1'b0}}, endpoint_fifo_clear};
         `USBDR_OFF_EP_CONTROL:  next_rdata = ep_rdata;
         `USBDR_OFF_EP_TYPE_DIR: next_rdata = ep_rdata;
         `USBDR_OFF_EP_SIZE_BANK: next_rdata = ep_rdata;
         default:                next_rdata = 8'h00;
      endcase
   end

   // Read data register, zero outside the cycle after a read
   always @(posedge clock)
   begin
      if (!reset_n)
         reg_rdata <= 8'h00;
      else if (reg_read)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= 8'h00;
   end

endmodule // usbdr_registers

// ===== src/usbdr_consts.vh
// Register offsets, field positions, reset values and size codes of the USB device registers
`ifndef USBDR_CONSTS_VH
`define USBDR_CONSTS_VH
`define USBDR_OFF_IRQ_FLAGS    8'h00
`define USBDR_OFF_IRQ_ENABLE   8'h01
`define USBDR_OFF_ADDRESS      8'h02
`define USBDR_OFF_FNUM_HIGH    8'h03
`define USBDR_OFF_FNUM_LOW     8'h04
`define USBDR_OFF_FRAME_CRC    8'h05
`define USBDR_OFF_EP_SELECT    8'h06
`define USBDR_OFF_EP_FIFO_RST  8'h07
`define USBDR_OFF_EP_CONTROL   8'h08
`define USBDR_OFF_EP_TYPE_DIR  8'h09
`define USBDR_OFF_EP_SIZE_BANK 8'h0A
`define USBDR_OFF_EP_STATE     8'h0B
`define USBDR_BIT_UPRSM        6
`define USBDR_BIT_EORSM        5
`define USBDR_BIT_WAKE         4
`define USBDR_BIT_EORST        3
`define USBDR_BIT_SOF          2
`define USBDR_BIT_SUSP         0
`define USBDR_IRQ_MASK         8'h7D
`define USBDR_IRQ_EN_RESET     8'h08
`define USBDR_BIT_ADDR_ACT     7
`define USBDR_BIT_FRAME_NUM_CRC_ERR       4
`define USBDR_BIT_STALL_REQ    5
`define USBDR_BIT_STALL_CANCEL 4
`define USBDR_BIT_TOGGLE_RST   3
`define USBDR_BIT_EP_ON        0
`define USBDR_EP_SEL_MASK      8'h07
`define USBDR_EP_FIFO_MASK     8'h7F
`define USBDR_TYPE_DIR_MASK    8'hC1
`define USBDR_SIZE_BANK_MASK   8'h74
`define USBDR_KIND_CONTROL     2'h0
`define USBDR_KIND_ISO         2'h1
`define USBDR_KIND_BULK        2'h2
`define USBDR_KIND_INTR        2'h3
`define USBDR_SIZE_RESERVED    3'h7
`endif

// ===== test/usbdr_registers_sva.sv
// Assertions on the ports of the USB device register bank
`timescale 1ns/1ps
module usbdr_registers_sva
#(
   parameter ENDPOINTS = 7
)
(
   // Clock, reset and register port
   input wire                 clock,
   input wire                 reset_n,
   input wire [7:0]           reg_addr,
   input wire [7:0]           reg_wdata,
   input wire                 reg_write,
   input wire                 reg_read,
   input wire [7:0]           reg_rdata,
   // Engine events and controls
   input wire                 ev_frame_start,
   input wire [10:0]          ev_frame_num,
   input wire                 ev_frame_crc_bad,
   input wire                 ev_addr_done,
   input wire [ENDPOINTS-1:0] ev_setup_rx,
   input wire                 address_activate,
   input wire [6:0]           device_addr_field,
   input wire [ENDPOINTS-1:0] stall_request,
   input wire [ENDPOINTS-1:0] stall_cancel,
   input wire [ENDPOINTS-1:0] toggle_reset
);
   reg [10:0] fnum_seen;
   reg        crc_seen;
   reg [7:0]  wd_q;
   always @(posedge clock)
   begin
      wd_q <= reg_wdata;
      if (!reset_n)
      begin
         fnum_seen <= 11'h000;
         crc_seen  <= 1'b0;
      end
      else if (ev_frame_start)
      begin
         fnum_seen <= ev_frame_num;
         crc_seen  <= ev_frame_crc_bad;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data not zero outside read");
   a_frame_high: assert property (reg_read && reg_addr == 8'h03 && !ev_frame_start
      |=> reg_rdata == {5'h00, fnum_seen[10:8]}) else $error("frame high wrong");
   a_frame_low: assert property (reg_read && reg_addr == 8'h04 && !ev_frame_start
      |=> reg_rdata == fnum_seen[7:0]) else $error("frame low wrong");
   a_crc_flag: assert property (reg_read && reg_addr == 8'h05 && !ev_frame_start
      |=> reg_rdata == {3'h0, crc_seen, 4'h0}) else $error("crc flag wrong");
   a_stall_setup: assert property ((ev_setup_rx & stall_request) != 0 && !reg_write
      |=> (stall_request & $past(ev_setup_rx)) == 0) else $error("stall not cleared");
   a_toggle_once: assert property (toggle_reset != 0
      |=> (toggle_reset & $past(toggle_reset)) == 0) else $error("toggle reset too long");
   a_cancel_once: assert property (stall_cancel != 0
      |=> (stall_cancel & $past(stall_cancel)) == 0) else $error("stall cancel too long");
   a_addr_write: assert property (reg_write && reg_addr == 8'h02 |=>
      device_addr_field == wd_q[6:0] && (address_activate || !wd_q[7]))
      else $error("address write lost");
   a_addr_hold: assert property (address_activate && !ev_addr_done |=> address_activate)
      else $error("address activate dropped");
   a_addr_done: assert property (ev_addr_done && !(reg_write && reg_addr == 8'h02)
      |=> !address_activate) else $error("address activate not cleared");
   cover property (ev_frame_start && ev_frame_crc_bad);
   cover property (toggle_reset != 0);
   cover property (address_activate ##1 !address_activate);
endmodule // usbdr_registers_sva
bind usbdr_registers usbdr_registers_sva #(.ENDPOINTS(ENDPOINTS)) u_usbdr_registers_sva (
   .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .ev_frame_start(ev_frame_start), .ev_frame_num(ev_frame_num),
   .ev_frame_crc_bad(ev_frame_crc_bad), .ev_addr_done(ev_addr_done),
   .ev_setup_rx(ev_setup_rx), .address_activate(address_activate),
   .device_addr_field(device_addr_field), .stall_request(stall_request),
   .stall_cancel(stall_cancel), .toggle_reset(toggle_reset));

// ===== test/usbdr_engine_model.sv
// Frame start source standing in for the serial engine
`timescale 1ns/1ps
module usbdr_engine_model
(
   // Clock and command
   input wire        clock,
   input wire        sof_go,
   input wire [10:0] sof_num,
   input wire        sof_bad,
   // Frame events
   output reg        ev_frame_start = 1'b0,
   output reg [10:0] ev_frame_num = 11'h000,
   output reg        ev_frame_crc_bad = 1'b0
);
   // Number and CRC status only hold during the frame start pulse
   always @(posedge clock)
   begin
      ev_frame_start   <= sof_go;
      ev_frame_num     <= sof_go ? sof_num : ~ev_frame_num;
      ev_frame_crc_bad <= sof_go ? sof_bad : ~ev_frame_crc_bad;
   end
endmodule // usbdr_engine_model

// ===== test/tb_usbdr_registers.sv
// Self-checking bench for the USB device register bank
`timescale 1ns/1ps
module tb_usbdr_registers;
   reg         clock = 1'b0;
   reg         reset_n = 1'b0;
   reg  [7:0]  reg_addr = 8'h00;
   reg  [7:0]  reg_wdata = 8'h00;
   reg         reg_write = 1'b0;
   reg         reg_read = 1'b0;
   reg  [6:0]  ev = 7'h00;
   reg         addr_done = 1'b0;
   reg  [6:0]  setup_rx = 7'h00;
   reg  [10:0] sof_num = 11'h000;
   reg         sof_bad = 1'b0;
   wire [7:0]  reg_rdata;
   wire        irq, frame_start, crc_bad, act;
   wire [10:0] frame_num;
   wire [6:0]  addr_f, stall, cancel, toggle, ep_on, fifo, dir;
   wire [13:0] kind, banks;
   wire [20:0] bytes;
   integer     mismatches = 0;
   integer     num_checks = 0;
   integer     i;
   reg  [23:0] rows [0:11];
   always #2.5 clock = ~clock;
   usbdr_engine_model u_usbdr_engine_model (.clock(clock), .sof_go(ev[2]), .sof_num(sof_num),
      .sof_bad(sof_bad), .ev_frame_start(frame_start), .ev_frame_num(frame_num),
      .ev_frame_crc_bad(crc_bad));
   usbdr_registers u_usbdr_registers (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .ev_upstream_resume(ev[6]), .ev_end_resume(ev[5]),
      .ev_wake(ev[4]), .ev_bus_reset_end(ev[3]), .ev_suspend(ev[0]),
      .ev_frame_start(frame_start), .ev_frame_num(frame_num), .ev_frame_crc_bad(crc_bad),
      .ev_addr_done(addr_done), .ev_setup_rx(setup_rx), .ev_stall_cancel_done(7'h00),
      .ev_toggle_reset_done(7'h00), .device_irq(irq), .device_addr_field(addr_f),
      .address_activate(act), .endpoint_fifo_clear(fifo), .endpoint_on(ep_on),
      .stall_request(stall), .stall_cancel(cancel), .toggle_reset(toggle),
      .transfer_kind(kind), .endpoint_direction(dir), .endpoint_bytes(bytes),
      .endpoint_bank_count(banks));
   task chk(input [7:0] got, input [7:0] exp);
   begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task tick;
   begin
      @(posedge clock);
      #1;
   end
   endtask
   task wr(input [7:0] a, input [7:0] d);
   begin
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      #1;
   end
   endtask
   task rd(input [7:0] a, input [7:0] exp);
   begin
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   end
   endtask
   task fire(input [6:0] m);
   begin
      @(posedge clock);
      ev <= m;
      @(posedge clock);
      ev <= 7'h00;
      #1;
   end
   endtask
   task summarize;
   begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   initial
   begin
      #100000;
      mismatches = mismatches + 1;
      summarize;
   end
   initial
   begin
      rows[0] = 24'h01FF7D;
      rows[1] = 24'h06FA02;
      rows[2] = 24'h07FF7F;
      rows[3] = 24'h098181;
      rows[4] = 24'h094141;
      rows[5] = 24'h09C1C1;
      rows[6] = 24'h090100;
      rows[7] = 24'h0A6464;
      rows[8] = 24'h080101;
      rows[9] = 24'h0BFF00;
      rows[10] = 24'h04FF00;
      rows[11] = 24'h022525;
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      rd(8'h01, 8'h08);
      rd(8'h00, 8'h00);
      $display("reset test done");
      for (i = 0; i < 12; i = i + 1)
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      chk({1'b0, fifo}, 8'h7F);
      wr(8'h07, 8'h00);
      rd(8'h07, 8'h00);
      chk({1'b0, fifo}, 8'h00);
      wr(8'h09, 8'h81);
      chk({kind[5:4], 5'h00, dir[2]}, 8'h81);
      wr(8'h0A, 8'h74);
      rd(8'h0A, 8'h64);
      wr(8'h0A, 8'h38);
      chk({1'b0, bytes[8:6], banks[5:4], 2'h0}, 8'h34);
      $display("table test done");
      wr(8'h01, 8'h00);
      fire(7'h7D);
      rd(8'h00, 8'h7D);
      chk({7'h00, irq}, 8'h00);
      for (i = 0; i < 8; i = i + 1)
      begin
         wr(8'h01, 8'h01 << i);
         tick;
         chk({7'h00, irq}, (8'h7D >> i) & 8'h01);
      end
      wr(8'h01, 8'h08);
      wr(8'h00, 8'hF7);
      rd(8'h00, 8'h75);
      chk({7'h00, irq}, 8'h00);
      wr(8'h00, 8'h00);
      wr(8'h00, 8'hFF);
      rd(8'h00, 8'h00);
      $display("flag test done");
      @(posedge clock);
      sof_num <= 11'h5A3;
      sof_bad <= 1'b1;
      fire(7'h04);
      rd(8'h03, 8'h05);
      rd(8'h04, 8'hA3);
      rd(8'h05, 8'h10);
      @(posedge clock);
      sof_num <= 11'h7FF;
      sof_bad <= 1'b0;
      fire(7'h04);
      rd(8'h03, 8'h07);
      rd(8'h05, 8'h00);
      rd(8'h00, 8'h04);
      $display("frame test done");
      wr(8'h02, 8'h85);
      chk({act, addr_f}, 8'h85);
      wr(8'h02, 8'h05);
      chk({act, addr_f}, 8'h85);
      @(posedge clock);
      addr_done <= 1'b1;
      @(posedge clock);
      addr_done <= 1'b0;
      #1;
      chk({act, addr_f}, 8'h05);
      wr(8'h08, 8'h29);
      chk({1'b0, toggle}, 8'h04);
      chk({1'b0, stall}, 8'h04);
      tick;
      chk({1'b0, toggle}, 8'h00);
      wr(8'h08, 8'h01);
      chk({1'b0, stall}, 8'h04);
      @(posedge clock);
      setup_rx <= 7'h04;
      @(posedge clock);
      setup_rx <= 7'h00;
      #1;
      chk({1'b0, stall}, 8'h00);
      wr(8'h08, 8'h11);
      chk({1'b0, cancel}, 8'h04);
      tick;
      chk({1'b0, cancel}, 8'h00);
      wr(8'h06, 8'h03);
      rd(8'h08, 8'h00);
      rd(8'h09, 8'h00);
      chk({1'b0, ep_on}, 8'h04);
      $display("endpoint test done");
      summarize;
   end
endmodule // tb_usbdr_registers
